// file: core/io_mem_address_decoder.sv
`timescale 1ns/1ps

// Behaviour
// - Every variable I/O window base comes from a software-set configuration input.
// - No overlap check between variable and fixed windows, no error raised.
// - Power 256 bytes, SMBus 32, watchdog 32; first to power, others to SMBus.
// - Parallel port 8 bytes at one of three locations, routed to eSPI.
// - Three serial ports, 8 bytes each, eight locations each, routed to eSPI.
// - Storage index/data window of 16 bytes routed to storage controller.
// - Keyboard-text 8 bytes, redirect 16/32 bytes, traps 1-256 bytes.
// - All variable I/O windows decode directly from upstream link cycles.
// - Upstream memory cycle hitting no internal target is master aborted.
// - Downstream memory cycles decoded positively except bridge forwarding range.
// - Downstream memory outside bridge and network controller ranges goes upstream.
// - 000E_0000 64 KB to flash only while enable bit 6 set.
// - 000F_0000 64 KB to flash only while enable bit 7 set.
// - Interrupt controller window FECX_X000-X040, XX from range select, enabled.
// - Per-port 4 KB windows, X inside base/limit, gated by port enable.
// - Fixed 32 KB per-port windows from FEC1_0000, gated by port enable.
// - Fixed per-port windows continue through port 27 ending FECE_FFFF.
module io_mem_address_decoder #(
  parameter int NUM_PORTS = io_mem_decode_pkg::NUM_PORTS,
  parameter int NUM_TRAPS = io_mem_decode_pkg::NUM_TRAPS
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         req_valid,
  input  wire io_mem_decode_pkg::req_t      req,
  input  wire logic [15:0]                  pm_base,
  input  wire logic                         pm_en,
  input  wire logic [15:0]                  smbus_base,
  input  wire logic                         smbus_en,
  input  wire logic [15:0]                  watchdog_window_base,
  input  wire logic                         watchdog_window_en,
  input  wire logic [15:0]                  storage_base,
  input  wire logic                         storage_en,
  input  wire logic [15:0]                  remote_kbd_text_base,
  input  wire logic                         remote_kbd_text_en,
  input  wire logic [15:0]                  remote_drive_redirect_base,
  input  wire logic                         remote_drive_redirect_size32,
  input  wire logic                         remote_drive_redirect_en,
  input  wire logic [1:0]                   par_sel,
  input  wire logic                         par_en,
  input  wire logic [2:0][2:0]              ser_sel,
  input  wire logic [2:0]                   ser_en,
  input  wire logic [NUM_TRAPS-1:0][15:0]   trap_base,
  input  wire logic [NUM_TRAPS-1:0][7:0]    trap_mask,
  input  wire logic [NUM_TRAPS-1:0]         trap_en,
  input  wire logic [15:0]                  fw_decode_en,
  input  wire logic [7:0]                   intc_range_select,
  input  wire logic                         intc_window_enable,
  input  wire logic [NUM_PORTS-1:0]         port_intc_window_enable,
  input  wire logic [NUM_PORTS-1:0][7:0]    port_intc_base,
  input  wire logic [NUM_PORTS-1:0][7:0]    port_intc_limit,
  input  wire logic [31:0]                  bridge_mem_base,
  input  wire logic [31:0]                  bridge_mem_limit,
  input  wire logic                         bridge_mem_en,
  input  wire logic [31:0]                  lan_base,
  input  wire logic                         lan_en,
  output logic                              route_valid,
  output io_mem_decode_pkg::route_t         route
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base,
                                   input int sz_log2);
    win_hit = ((a ^ base) >> sz_log2) == 32'h0000_0000;
  endfunction : win_hit

  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // ----------------------------------------------------------------
  // I/O windows, all decoded from the upstream link
  // ----------------------------------------------------------------
  logic [31:0] a;
  logic [31:0] io_a;
  logic        up_io;
  logic        up_mem;
  logic        dn_mem;
  logic        dn_io;

  assign a      = req.addr;
  assign io_a   = {16'h0000, req.addr[15:0]};
  assign up_io  = req_valid && !req.from_down && !req.is_mem;
  assign up_mem = req_valid && !req.from_down && req.is_mem;
  assign dn_mem = req_valid && req.from_down && req.is_mem;
  assign dn_io  = req_valid && req.from_down && !req.is_mem;

  // Bases are software values only; nothing compares them to fixed ranges
  logic hit_pm;
  logic hit_smb;
  logic hit_wdt;
  logic hit_stor;
  logic hit_kbd;
  logic hit_red;
  logic hit_par;
  logic [2:0] hit_ser;
  logic [NUM_TRAPS-1:0] hit_trap;
  int   red_log2;

  assign hit_pm   = pm_en && win_hit(io_a, {16'h0000, pm_base},
                                     io_mem_decode_pkg::PM_SZ_LOG2);
  assign hit_smb  = smbus_en && win_hit(io_a, {16'h0000, smbus_base},
                                        io_mem_decode_pkg::SMB_SZ_LOG2);
  assign hit_wdt  = watchdog_window_en &&
                    win_hit(io_a, {16'h0000, watchdog_window_base},
                            io_mem_decode_pkg::WDT_SZ_LOG2);
  assign hit_stor = storage_en && win_hit(io_a, {16'h0000, storage_base},
                                          io_mem_decode_pkg::STOR_SZ_LOG2);
  assign hit_kbd  = remote_kbd_text_en &&
                    win_hit(io_a, {16'h0000, remote_kbd_text_base},
                            io_mem_decode_pkg::KBD_SZ_LOG2);
  assign red_log2 = remote_drive_redirect_size32 ? io_mem_decode_pkg::RED32_SZ_LOG2
                                                 : io_mem_decode_pkg::RED16_SZ_LOG2;
  assign hit_red  = remote_drive_redirect_en &&
                    win_hit(io_a, {16'h0000, remote_drive_redirect_base}, red_log2);
  // Selector value 3 names no location and leaves the window closed
  assign hit_par  = par_en && (par_sel != 2'b11) &&
                    win_hit(io_a, {16'h0000, io_mem_decode_pkg::PAR_LOC[par_sel]},
                            io_mem_decode_pkg::LEG_SZ_LOG2);

  for (genvar s = 0; s < 3; s++) begin : g_ser
    assign hit_ser[s] = ser_en[s] &&
                        win_hit(io_a, {16'h0000, io_mem_decode_pkg::SER_LOC[ser_sel[s]]},
                                io_mem_decode_pkg::LEG_SZ_LOG2);
  end

  // Mask bits widen the trap window from 1 up to 256 bytes
  for (genvar t = 0; t < NUM_TRAPS; t++) begin : g_trap
    assign hit_trap[t] = trap_en[t] &&
                         (((io_a[15:0] ^ trap_base[t]) & ~{8'h00, trap_mask[t]}) == 16'h0000);
  end

  // ----------------------------------------------------------------
  // Memory windows from the upstream link
  // ----------------------------------------------------------------
  logic hit_fw_e;
  logic hit_fw_f;
  logic hit_intc;
  logic [NUM_PORTS-1:0] hit_pwin;
  logic [NUM_PORTS-1:0] hit_pfix;

  assign hit_fw_e = fw_decode_en[io_mem_decode_pkg::FW_E_EN_BIT] &&
                    win_hit(a, io_mem_decode_pkg::FW_E_BASE,
                            io_mem_decode_pkg::FW_SZ_LOG2);
  assign hit_fw_f = fw_decode_en[io_mem_decode_pkg::FW_F_EN_BIT] &&
                    win_hit(a, io_mem_decode_pkg::FW_F_BASE,
                            io_mem_decode_pkg::FW_SZ_LOG2);
  // Window is inclusive of offset 040
  assign hit_intc = intc_window_enable && (a[31:20] == io_mem_decode_pkg::INTC_TOP) &&
                    (a[19:12] == intc_range_select) &&
                    (a[11:0] <= io_mem_decode_pkg::INTC_LAST_OFS);

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [31:0] FIX_BASE = io_mem_decode_pkg::PFIX_BASE +
                                       io_mem_decode_pkg::PFIX_STEP * p;
    assign hit_pwin[p] = port_intc_window_enable[p] &&
                         (a[31:20] == io_mem_decode_pkg::INTC_TOP) &&
                         (a[19:12] >= port_intc_base[p]) &&
                         (a[19:12] <= port_intc_limit[p]);
    assign hit_pfix[p] = port_intc_window_enable[p] &&
                         win_hit(a, FIX_BASE, io_mem_decode_pkg::PFIX_SZ_LOG2);
  end

  // ----------------------------------------------------------------
  // Downstream memory
  // ----------------------------------------------------------------
  logic hit_bridge;
  logic hit_lan;

  assign hit_bridge = bridge_mem_en && (a >= bridge_mem_base) && (a <= bridge_mem_limit);
  assign hit_lan    = lan_en && win_hit(a, lan_base, io_mem_decode_pkg::LAN_SZ_LOG2);

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  // Order on upstream I/O: power, SMBus, watchdog, storage, keyboard,
  // redirect, parallel, serial 1-3, traps. Upstream memory: flash E, flash F,
  // interrupt controller, port 4 KB windows, port fixed windows.
  io_mem_decode_pkg::route_t io_route;
  io_mem_decode_pkg::route_t mem_route;
  io_mem_decode_pkg::route_t dn_route;
  io_mem_decode_pkg::route_t route_d;
  logic [31:0] pwin_vec;
  logic [31:0] pfix_vec;

  assign pwin_vec = 32'(hit_pwin);
  assign pfix_vec = 32'(hit_pfix);

  always_comb begin
    io_route = '{target: io_mem_decode_pkg::TGT_NONE, port: 5'h00, abort: 1'b1};
    if (hit_pm) begin
      io_route = '{target: io_mem_decode_pkg::TGT_PM, port: 5'h00, abort: 1'b0};
    end else if (hit_smb || hit_wdt) begin
      io_route = '{target: io_mem_decode_pkg::TGT_SMBUS, port: 5'h00, abort: 1'b0};
    end else if (hit_stor) begin
      io_route = '{target: io_mem_decode_pkg::TGT_STORAGE, port: 5'h00, abort: 1'b0};
    end else if (hit_kbd) begin
      io_route = '{target: io_mem_decode_pkg::TGT_KBD_TEXT, port: 5'h00, abort: 1'b0};
    end else if (hit_red) begin
      io_route = '{target: io_mem_decode_pkg::TGT_REDIRECT, port: 5'h00, abort: 1'b0};
    end else if (hit_par || (|hit_ser)) begin
      io_route = '{target: io_mem_decode_pkg::TGT_ESPI, port: 5'h00, abort: 1'b0};
    end else if (|hit_trap) begin
      io_route = '{target: io_mem_decode_pkg::TGT_TRAP, port: 5'h00, abort: 1'b0};
    end
  end

  always_comb begin
    mem_route = '{target: io_mem_decode_pkg::TGT_NONE, port: 5'h00, abort: 1'b1};
    if (hit_fw_e || hit_fw_f) begin
      mem_route = '{target: io_mem_decode_pkg::TGT_FLASH, port: 5'h00, abort: 1'b0};
    end else if (hit_intc) begin
      mem_route = '{target: io_mem_decode_pkg::TGT_INTC, port: 5'h00, abort: 1'b0};
    end else if (|hit_pwin) begin
      mem_route = '{target: io_mem_decode_pkg::TGT_ROOTPORT, port: first_set(pwin_vec),
                    abort: 1'b0};
    end else if (|hit_pfix) begin
      mem_route = '{target: io_mem_decode_pkg::TGT_ROOTPORT, port: first_set(pfix_vec),
                    abort: 1'b0};
    end
  end

  always_comb begin
    dn_route = '{target: io_mem_decode_pkg::TGT_UPSTREAM, port: 5'h00, abort: 1'b0};
    if (dn_mem && hit_bridge) begin
      dn_route = '{target: io_mem_decode_pkg::TGT_PEER, port: 5'h00, abort: 1'b0};
    end else if (dn_mem && hit_lan) begin
      dn_route = '{target: io_mem_decode_pkg::TGT_LAN, port: 5'h00, abort: 1'b0};
    end
  end

  assign route_d = up_io  ? io_route :
                   up_mem ? mem_route :
                   (dn_mem || dn_io) ? dn_route : io_mem_decode_pkg::ROUTE_RST;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic                      route_valid_q;
  io_mem_decode_pkg::route_t route_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      route_valid_q <= 1'b0;
      route_q       <= io_mem_decode_pkg::ROUTE_RST;
    end else begin
      route_valid_q <= req_valid;
      route_q       <= route_d;
    end
  end

  assign route_valid = route_valid_q;
  assign route       = route_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_valid_latency: assert property (req_valid |=> route_valid)
    else $error("route_valid missing one cycle after request");

  chk_idle_quiet: assert property (!req_valid |=> !route_valid && !route.abort)
    else $error("answer without a request");

  chk_abort_none: assert property (route.abort |-> route.target == io_mem_decode_pkg::TGT_NONE)
    else $error("aborted cycle carries a target");

  chk_dn_io_up: assert property (dn_io |=> route.target == io_mem_decode_pkg::TGT_UPSTREAM)
    else $error("downstream I/O not forwarded");

  chk_up_mem_abort: assert property (up_mem && !hit_fw_e && !hit_fw_f && !hit_intc &&
                                     !(|hit_pwin) && !(|hit_pfix) |=> route.abort)
    else $error("unclaimed upstream memory cycle not aborted");

  chk_flash_e_gate: assert property (up_mem && win_hit(a, io_mem_decode_pkg::FW_E_BASE,
                                     io_mem_decode_pkg::FW_SZ_LOG2) |=>
                                     ((route.target == io_mem_decode_pkg::TGT_FLASH) ==
                                      $past(fw_decode_en[io_mem_decode_pkg::FW_E_EN_BIT])))
    else $error("low firmware window routing disagrees with enable bit 6");

  chk_flash_f_gate: assert property (up_mem && win_hit(a, io_mem_decode_pkg::FW_F_BASE,
                                     io_mem_decode_pkg::FW_SZ_LOG2) |=>
                                     ((route.target == io_mem_decode_pkg::TGT_FLASH) ==
                                      $past(fw_decode_en[io_mem_decode_pkg::FW_F_EN_BIT])))
    else $error("high firmware window routing disagrees with enable bit 7");

  chk_intc_claim: assert property (up_mem && !hit_fw_e && !hit_fw_f && hit_intc |=>
                                   route.target == io_mem_decode_pkg::TGT_INTC)
    else $error("interrupt controller window not claimed");

  chk_port_fix: assert property (up_mem && (a == 32'hFECE_FFFF) &&
                                 port_intc_window_enable[NUM_PORTS-1] && !(|hit_pwin) |=>
                                 route.target == io_mem_decode_pkg::TGT_ROOTPORT &&
                                 route.port == 5'(NUM_PORTS-1))
    else $error("top fixed window not sent to last port");

  chk_dn_upstream: assert property (dn_mem && !hit_bridge && !hit_lan |=>
                                    route.target == io_mem_decode_pkg::TGT_UPSTREAM)
    else $error("downstream memory cycle not forwarded upstream");

  chk_dn_bridge: assert property (dn_mem && hit_bridge |=>
                                  route.target == io_mem_decode_pkg::TGT_PEER && !route.abort)
    else $error("bridge range cycle was claimed");

  chk_pm_route: assert property (up_io && hit_pm |=>
                                 route.target == io_mem_decode_pkg::TGT_PM)
    else $error("power window hit misrouted");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  cov_up_abort: cover property (route_valid && route.abort);
  cov_flash_hit: cover property (route_valid && route.target == io_mem_decode_pkg::TGT_FLASH);
  cov_port_hit: cover property (route_valid && route.target == io_mem_decode_pkg::TGT_ROOTPORT);
  cov_espi_hit: cover property (route_valid && route.target == io_mem_decode_pkg::TGT_ESPI);
  cov_lan_hit:  cover property (route_valid && route.target == io_mem_decode_pkg::TGT_LAN);

endmodule : io_mem_address_decoder

// file: core/io_mem_decode_pkg.sv
package io_mem_decode_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 28;
  localparam int NUM_TRAPS = 4;
  localparam int PORT_W    = 5;

  // ----------------------------------------------------------------
  // Window sizes as log2 of bytes
  // ----------------------------------------------------------------
  localparam int PM_SZ_LOG2    = 8;
  localparam int SMB_SZ_LOG2   = 5;
  localparam int WDT_SZ_LOG2   = 5;
  localparam int LEG_SZ_LOG2   = 3;
  localparam int STOR_SZ_LOG2  = 4;
  localparam int KBD_SZ_LOG2   = 3;
  localparam int RED16_SZ_LOG2 = 4;
  localparam int RED32_SZ_LOG2 = 5;
  localparam int FW_SZ_LOG2    = 16;
  localparam int PFIX_SZ_LOG2  = 15;
  localparam int PWIN_SZ_LOG2  = 12;
  localparam int LAN_SZ_LOG2   = 17;

  // ----------------------------------------------------------------
  // Fixed memory addresses and enable bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] FW_E_BASE      = 32'h000E_0000;
  localparam logic [31:0] FW_F_BASE      = 32'h000F_0000;
  localparam int          FW_E_EN_BIT    = 6;
  localparam int          FW_F_EN_BIT    = 7;
  localparam logic [11:0] INTC_TOP       = 12'h0FEC;
  localparam logic [11:0] INTC_LAST_OFS  = 12'h0040;
  localparam logic [31:0] PFIX_BASE      = 32'hFEC1_0000;
  localparam logic [31:0] PFIX_STEP      = 32'h0000_8000;

  // Legacy candidate I/O locations; plain defaults
  localparam logic [2:0][15:0] PAR_LOC = {16'h03BC, 16'h0278, 16'h0378};
  localparam logic [7:0][15:0] SER_LOC = {16'h03E8, 16'h0338, 16'h02E8, 16'h0238,
                                          16'h0228, 16'h0220, 16'h02F8, 16'h03F8};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TGT_NONE     = 4'h0,
    TGT_PM       = 4'h1,
    TGT_SMBUS    = 4'h2,
    TGT_ESPI     = 4'h3,
    TGT_STORAGE  = 4'h4,
    TGT_KBD_TEXT = 4'h5,
    TGT_REDIRECT = 4'h6,
    TGT_TRAP     = 4'h7,
    TGT_FLASH    = 4'h8,
    TGT_INTC     = 4'h9,
    TGT_ROOTPORT = 4'hA,
    TGT_LAN      = 4'hB,
    TGT_UPSTREAM = 4'hC,
    TGT_PEER     = 4'hD
  } target_t;

  typedef struct packed {
    logic        is_mem;
    logic        from_down;
    logic [31:0] addr;
  } req_t;

  typedef struct packed {
    target_t           target;
    logic [PORT_W-1:0] port;
    logic              abort;
  } route_t;

  localparam route_t ROUTE_RST = '{target: TGT_NONE, port: 5'h00, abort: 1'b0};

endpackage : io_mem_decode_pkg

// file: tb/link_master_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Upstream link and downstream masters, one request per cycle
// ----------------------------------------------------------------
module link_master_model (
  input  wire logic              clk_sys,
  output logic                   req_valid,
  output io_mem_decode_pkg::req_t req
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Plain cycles only; no locked cycle can be built here
  task automatic send(input io_mem_decode_pkg::req_t r);
    @(posedge clk_sys);
    #2;
    req_valid = 1'b1;
    req       = r;
  endtask : send

  // Released lines show the inverse, so a stale request cannot pass for a live one
  task automatic idle();
    @(posedge clk_sys);
    #2;
    req_valid = 1'b0;
    req       = ~req;
  endtask : idle
endmodule : link_master_model

// file: tb/io_mem_address_decoder_tb.sv
`timescale 1ns/1ps

module io_mem_address_decoder_tb;
  // ----------------------------------------------------------------
  // Stimulus, configuration and model state
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid, route_valid, exp_v;
  io_mem_decode_pkg::req_t req, r;
  io_mem_decode_pkg::route_t route, exp_r;
  // Every variable base sits clear of the fixed I/O ranges
  logic [15:0] pm_base = 16'h0400, smbus_base = 16'h0EE0, watchdog_window_base = 16'h0460;
  logic [15:0] storage_base = 16'h0C10, remote_kbd_text_base = 16'h0C28;
  logic [15:0] remote_drive_redirect_base = 16'h0C40, fw_decode_en;
  logic pm_en, smbus_en, watchdog_window_en, storage_en, remote_kbd_text_en, par_en, lan_en;
  logic remote_drive_redirect_en, remote_drive_redirect_size32, bridge_mem_en, intc_window_enable;
  logic [1:0] par_sel;
  logic [2:0] ser_en;
  logic [2:0][2:0] ser_sel;
  logic [3:0][15:0] trap_base = {16'h0F00, 16'h0E00, 16'h0D00, 16'h0C40};
  logic [3:0][7:0] trap_mask = {8'h0F, 8'h00, 8'hFF, 8'h3F};
  logic [3:0] trap_en;
  logic [7:0] intc_range_select;
  logic [27:0] port_intc_window_enable;
  logic [27:0][7:0] port_intc_base, port_intc_limit;
  logic [31:0] bridge_mem_base = 32'h8000_0000, bridge_mem_limit = 32'h8FFF_FFFF;
  logic [31:0] lan_base = 32'h9000_0000, w;
  int errors = 0;
  int checks = 0;
  integer seed = 32'h76a5_cc52;

  always #10 clk_sys = ~clk_sys;

  io_mem_address_decoder dut_u (.*);
  link_master_model src_u (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));

  // ----------------------------------------------------------------
  // Reference decode, first match wins
  // ----------------------------------------------------------------
  function automatic io_mem_decode_pkg::route_t exp_route(io_mem_decode_pkg::req_t q);
    io_mem_decode_pkg::route_t e;
    logic [15:0] a;
    logic [31:0] m, fb;
    logic espi, trap;
    int p4, pf;
    e = io_mem_decode_pkg::ROUTE_RST;
    a = q.addr[15:0];
    m = q.addr;
    espi = par_en && par_sel != 2'h3 && a[15:3] == io_mem_decode_pkg::PAR_LOC[par_sel][15:3];
    trap = 1'b0;
    p4 = -1;
    pf = -1;
    for (int i = 0; i < 3; i++)
      espi |= ser_en[i] && a[15:3] == io_mem_decode_pkg::SER_LOC[ser_sel[i]][15:3];
    for (int i = 0; i < 4; i++)
      trap |= trap_en[i] && ((a ^ trap_base[i]) & ~{8'h00, trap_mask[i]}) == 16'h0000;
    // Walk downwards so the lowest enabled port is left standing
    for (int i = 27; i >= 0; i--) begin
      fb = 32'hFEC1_0000 + 32'(i) * 32'h0000_8000;
      if (port_intc_window_enable[i] && m[31:20] == 12'hFEC && m[19:12] >= port_intc_base[i]
          && m[19:12] <= port_intc_limit[i]) p4 = i;
      if (port_intc_window_enable[i] && m[31:15] == fb[31:15]) pf = i;
    end
    if (q.from_down) begin
      if (q.is_mem && bridge_mem_en && m >= bridge_mem_base && m <= bridge_mem_limit)
        e.target = io_mem_decode_pkg::TGT_PEER;
      else if (q.is_mem && lan_en && m[31:17] == lan_base[31:17])
        e.target = io_mem_decode_pkg::TGT_LAN;
      else e.target = io_mem_decode_pkg::TGT_UPSTREAM;
    end else if (!q.is_mem) begin
      if (pm_en && a[15:8] == pm_base[15:8]) e.target = io_mem_decode_pkg::TGT_PM;
      else if ((smbus_en && a[15:5] == smbus_base[15:5]) ||
               (watchdog_window_en && a[15:5] == watchdog_window_base[15:5]))
        e.target = io_mem_decode_pkg::TGT_SMBUS;
      else if (storage_en && a[15:4] == storage_base[15:4])
        e.target = io_mem_decode_pkg::TGT_STORAGE;
      else if (remote_kbd_text_en && a[15:3] == remote_kbd_text_base[15:3])
        e.target = io_mem_decode_pkg::TGT_KBD_TEXT;
      else if (remote_drive_redirect_en && ((a ^ remote_drive_redirect_base) >>
               (remote_drive_redirect_size32 ? 5 : 4)) == 16'h0000)
        e.target = io_mem_decode_pkg::TGT_REDIRECT;
      else if (espi) e.target = io_mem_decode_pkg::TGT_ESPI;
      else if (trap) e.target = io_mem_decode_pkg::TGT_TRAP;
      else e.abort = 1'b1;
    end else begin
      if ((fw_decode_en[6] && m[31:16] == 16'h000E) || (fw_decode_en[7] && m[31:16] == 16'h000F))
        e.target = io_mem_decode_pkg::TGT_FLASH;
      else if (intc_window_enable && m[31:12] == {12'hFEC, intc_range_select}
               && m[11:0] <= 12'h040) e.target = io_mem_decode_pkg::TGT_INTC;
      else if (p4 >= 0 || pf >= 0) begin
        e.target = io_mem_decode_pkg::TGT_ROOTPORT;
        e.port   = (p4 >= 0) ? 5'(p4) : 5'(pf);
      end else e.abort = 1'b1;
    end
    return e;
  endfunction : exp_route

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      exp_v <= 1'b0;
      exp_r <= io_mem_decode_pkg::ROUTE_RST;
    end else begin
      exp_v <= req_valid;
      exp_r <= req_valid ? exp_route(req) : io_mem_decode_pkg::ROUTE_RST;
    end
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] expd);
    checks++;
    if (seen !== expd) begin
      errors++;
      $display("[ERR] %0t route seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  always @(negedge clk_sys) check({route_valid, route}, {exp_v, exp_r});

  task automatic probe(input logic [1:0] k, input logic [31:0] a, input logic [3:0] t,
                       input logic [4:0] p, input logic ab);
    src_u.send('{is_mem: k[0], from_down: k[1], addr: a});
    @(posedge clk_sys);
    #5;
    check({route_valid, route}, {1'b1, t, p, ab});
  endtask : probe

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {pm_en, smbus_en, watchdog_window_en, storage_en, remote_kbd_text_en, par_en, lan_en} = '1;
    {remote_drive_redirect_en, remote_drive_redirect_size32, bridge_mem_en} = '1;
    {intc_window_enable, ser_en, trap_en, port_intc_window_enable} = '1;
    {par_sel, ser_sel, intc_range_select, fw_decode_en} = {2'h1, 9'o720, 8'h25, 16'h00C0};
    for (int i = 0; i < 28; i++) begin
      port_intc_base[i]  = 8'(i * 8);
      port_intc_limit[i] = 8'(i * 8 + 3);
    end
    repeat (3) @(posedge clk_sys);
    #2 rst_b = 1'b1;
    probe(2'h0, 32'h0000_0465, 4'h1, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0EFF, 4'h2, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0C1F, 4'h4, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0C2F, 4'h5, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0C5F, 4'h6, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_027F, 4'h3, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0227, 4'h3, 5'h00, 1'b0);
    probe(2'h0, 32'h0000_0E01, 4'h0, 5'h00, 1'b1);
    probe(2'h1, 32'h000F_FFFF, 4'h8, 5'h00, 1'b0);
    probe(2'h1, 32'hFEC2_5040, 4'h9, 5'h00, 1'b0);
    probe(2'h1, 32'hFEC2_5041, 4'hA, 5'h02, 1'b0);
    probe(2'h1, 32'hFEC1_9000, 4'hA, 5'h03, 1'b0);
    probe(2'h1, 32'hFECE_FFFF, 4'hA, 5'h1B, 1'b0);
    probe(2'h1, 32'hFECF_0000, 4'h0, 5'h00, 1'b1);
    probe(2'h3, 32'h8FFF_FFFF, 4'hD, 5'h00, 1'b0);
    probe(2'h3, 32'h9002_0000, 4'hC, 5'h00, 1'b0);
    probe(2'h2, 32'h0000_0465, 4'hC, 5'h00, 1'b0);
    fw_decode_en = 16'h0080;
    probe(2'h1, 32'h000E_0000, 4'h0, 5'h00, 1'b1);
    for (int i = 0; i < 800; i++) begin
      w = $random(seed);
      {remote_drive_redirect_size32, bridge_mem_en, intc_window_enable, ser_en} = w[5:0];
      {pm_en, smbus_en, watchdog_window_en, storage_en, remote_kbd_text_en} = w[10:6];
      {par_en, lan_en, remote_drive_redirect_en, trap_en, par_sel, ser_sel} = w[28:11];
      w = $random(seed);
      {fw_decode_en, intc_range_select} = w[23:0];
      w = $random(seed);
      port_intc_window_enable = w[27:0];
      w = $random(seed);
      r.is_mem = w[0];
      r.from_down = w[1];
      case (w[6:4])
        3'h0: r.addr = 32'h0000_0400 + 32'(w[31:24]);
        3'h1: r.addr = 32'h0000_0C00 + 32'(w[31:22]);
        3'h2: r.addr = 32'h0000_0200 + 32'(w[31:23]);
        3'h3: r.addr = 32'h000D_8000 + 32'(w[31:15]);
        3'h4: r.addr = 32'hFEC0_0000 + 32'(w[31:12]);
        3'h5: r.addr = {12'hFEC, intc_range_select, 12'h000} + 32'(w[31:25]);
        3'h6: r.addr = 32'h8FFE_0000 + 32'(w[31:13]);
        default: r.addr = w;
      endcase
      if (w[3]) src_u.send(r);
      else src_u.idle();
      // Reset dropped mid-traffic must clear the answer and lose the pending request
      if (i == 400) rst_b = 1'b0;
      if (i == 402) rst_b = 1'b1;
    end
    src_u.idle();
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
endmodule : io_mem_address_decoder_tb
